// ### core/fpioc_cell.sv
// pin i/o logic cell: capture, drive, drive-enable, alternate and pulls
// Summary of operation
// [R1] input mode enables only receive path, direct or through capture register
// [R2] registered receive path clocked by input clock, chosen edge
// [R3] registered input data reaches core only from capture register
// [R4] alternate input bypasses every capture register
// [R5] alternate input feeds another block, not through core interface
// [R6] dual-edge input: rise and fall registers give two streams
// [R7] output mode enables only drive path, output clock on chosen edge
// [R8] output register holds core values before the pad
// [R9] option inverts output register value toward the pad
// [R10] dual-edge output: rise and fall registers merged into one stream
// [R11] bidirectional mode: receive, drive, enable paths all active
// [R12] bidirectional: input clock for input, output clock for out and enable
// [R13] each register has its own edge polarity
// [R14] receive and drive registering chosen independently
// [R15] drive-enable register switches the pad output buffer
// [R16] clock-output mode forwards core clock tree to the pad
// [R17] weak pull-up on every pin during configuration
// [R18] unused pins in user mode: tristated with weak pull-up
// [R19] unused pin pull can be changed to weak pull-down
// [R20] high-speed cell offers 1:4 serializer/deserializer, full rate only
// [R21] dual-edge: first bit rising sample, second bit falling sample
// [R22] resync and pipeline variants present both bits on rising edge
// [R23] inactive drive-enable releases the pad whatever the data
// [R24] core gives dual-edge output bits one output-clock cycle ahead
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module fpioc_cell #(
  parameter bit FPIOC_HIGH_SPEED = 1'b1
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        cfg_busy_in,
  input  wire logic        in_clk_in,
  input  wire logic        out_clk_in,
  input  wire logic        clk_tree_in,
  input  wire logic [1:0]  core_out_in,
  input  wire logic        core_oe_in,
  output logic      [1:0]  core_in_out,
  output logic             alt_out,
  input  wire logic        pad_in,
  output logic             pad_out_out,
  output logic             pad_oe_out,
  output logic             pull_up_out,
  output logic             pull_down_out
);

  fpioc_pkg::fpioc_cfg_t cfg;
  logic [3:0]  ser_tx;
  logic [3:0]  ser_rx;
  logic        in_clk_q;
  logic        out_clk_q;
  logic        tree_q;
  logic        in_cap;
  logic        rise_cap;
  logic        fall_cap;
  logic [1:0]  rs_pair;
  logic [1:0]  pl_pair;
  logic        out_q;
  logic        d_rise;
  logic        d_fall_hold;
  logic        d_fall;
  logic        oe_q;
  logic [3:0]  tx_hold;
  logic        ser_bit;
  logic [1:0]  tx_cnt;
  logic [3:0]  rx_shift;
  logic [1:0]  rx_cnt;

  // clock edges seen on the system clock; the core clocks are slow enough
  // to be sampled, so one cycle of latency is the price for a single domain
  wire in_rise   = in_clk_in & ~in_clk_q;
  wire in_fall   = ~in_clk_in & in_clk_q;
  wire out_rise  = out_clk_in & ~out_clk_q;
  wire out_fall  = ~out_clk_in & out_clk_q;
  wire in_edge   = cfg.in_edge_fall ? in_fall : in_rise;    // [R13]
  wire out_edge  = cfg.out_edge_fall ? out_fall : out_rise; // [R13]
  wire oe_edge   = cfg.oe_edge_fall ? out_fall : out_rise;  // [R13]

  wire user_mode = ~cfg_busy_in;
  wire live      = user_mode & cfg.pin_used;
  wire rx_on     = live & (cfg.mode == fpioc_pkg::FPIOC_IN |
                           cfg.mode == fpioc_pkg::FPIOC_BIDIR); // [R1] [R11]
  wire tx_on     = live & (cfg.mode == fpioc_pkg::FPIOC_OUT |
                           cfg.mode == fpioc_pkg::FPIOC_BIDIR); // [R7] [R11]
  wire clk_on    = live & (cfg.mode == fpioc_pkg::FPIOC_CLKOUT); // [R16]
  wire serdes_on = cfg.serdes_en & FPIOC_HIGH_SPEED;           // [R20]

  // wishbone decode
  wire wb_req    = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire wb_wr     = wb_req & wb_we_in;
  wire hit_ctrl  = wb_adr_in == fpioc_pkg::FPIOC_ADR_CTRL;
  wire hit_stat  = wb_adr_in == fpioc_pkg::FPIOC_ADR_STAT;
  wire hit_tx    = wb_adr_in == fpioc_pkg::FPIOC_ADR_SER_TX;
  wire hit_rx    = wb_adr_in == fpioc_pkg::FPIOC_ADR_SER_RX;

  logic [15:0] next_ctrl;
  always_comb begin
    next_ctrl = cfg;
    if (wb_wr && hit_ctrl && wb_sel_in[0]) begin
      next_ctrl[7:0] = wb_dat_in[7:0];
    end
    if (wb_wr && hit_ctrl && wb_sel_in[1]) begin
      next_ctrl[15:8] = wb_dat_in[15:8];
    end
  end

  wire [5:0] stat_word = {cfg_busy_in, alt_out, pad_oe_out,
                          core_in_out, pad_in};

  wire [31:0] next_rdata =
    hit_ctrl ? {16'h0000, cfg} :
    hit_stat ? {26'h0000000, stat_word} :
    hit_tx   ? {28'h0000000, ser_tx} :
    hit_rx   ? {28'h0000000, ser_rx} : 32'h00000000;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg        <= fpioc_pkg::fpioc_cfg_t'(fpioc_pkg::FPIOC_CTRL_RST);
      ser_tx     <= fpioc_pkg::FPIOC_SER_RST;
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      cfg        <= fpioc_pkg::fpioc_cfg_t'(next_ctrl);
      wb_ack_out <= wb_req;
      if (wb_req) begin
        wb_dat_out <= next_rdata;
      end
      if (wb_wr && hit_tx && wb_sel_in[0]) begin
        ser_tx <= wb_dat_in[3:0];
      end
    end
  end

  // receive path registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_clk_q <= 1'b0;
      in_cap   <= 1'b0;
      rise_cap <= 1'b0;
      fall_cap <= 1'b0;
      rs_pair  <= 2'h0;
      pl_pair  <= 2'h0;
      rx_shift <= 4'h0;
      rx_cnt   <= 2'h0;
      ser_rx   <= fpioc_pkg::FPIOC_SER_RST;
    end else begin
      in_clk_q <= in_clk_in;
      if (in_edge) begin
        in_cap <= pad_in;                  // [R2] [R3]
      end
      if (in_rise) begin
        rise_cap <= pad_in;                // [R6] [R21]
        rs_pair  <= {fall_cap, rise_cap};  // [R22]
        pl_pair  <= rs_pair;               // [R22]
      end
      if (in_fall) begin
        fall_cap <= pad_in;                // [R6] [R21]
      end
      if (in_rise && serdes_on) begin
        rx_shift <= {pad_in, rx_shift[3:1]};  // [R20]
        rx_cnt   <= rx_cnt + 2'h1;
        if (rx_cnt == fpioc_pkg::FPIOC_SER_LAST) begin
          ser_rx <= {pad_in, rx_shift[3:1]};
        end
      end
    end
  end

  // drive and drive-enable registers, all on the output clock
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_clk_q   <= 1'b0;
      tree_q      <= 1'b0;
      out_q       <= 1'b0;
      d_rise      <= 1'b0;
      d_fall_hold <= 1'b0;
      d_fall      <= 1'b0;
      oe_q        <= 1'b0;
      tx_hold     <= 4'h0;
      ser_bit     <= 1'b0;
      tx_cnt      <= 2'h0;
    end else begin
      out_clk_q <= out_clk_in;
      tree_q    <= clk_tree_in;
      if (out_edge) begin
        out_q <= core_out_in[0];           // [R7] [R8] [R12]
      end
      if (oe_edge) begin
        oe_q <= core_oe_in;                // [R12] [R15]
      end
      if (out_rise) begin
        d_rise      <= core_out_in[0];     // [R10] [R24]
        d_fall_hold <= core_out_in[1];     // [R10] [R24]
      end
      if (out_fall) begin
        d_fall <= d_fall_hold;             // [R10]
      end
      if (out_rise && serdes_on) begin
        tx_cnt  <= tx_cnt + 2'h1;          // [R20]
        ser_bit <= (tx_cnt == 2'h0) ? ser_tx[0] : tx_hold[tx_cnt];
        if (tx_cnt == 2'h0) begin
          tx_hold <= ser_tx;
        end
      end
    end
  end

  // receive value toward the core
  logic [1:0] next_core_in;
  always_comb begin
    next_core_in = 2'h0;
    if (rx_on && cfg.dual_edge_io) begin
      case (cfg.dual_edge_io_kind)
        fpioc_pkg::FPIOC_DUAL_EDGE_IO_RESYNC: next_core_in = rs_pair;  // [R22]
        fpioc_pkg::FPIOC_DUAL_EDGE_IO_PIPE:   next_core_in = pl_pair;  // [R22]
        default: next_core_in = {fall_cap, rise_cap};          // [R21]
      endcase
    end else if (rx_on && cfg.in_reg_en) begin
      next_core_in = {1'b0, in_cap};                           // [R3] [R14]
    end else if (rx_on) begin
      next_core_in = {1'b0, pad_in};                           // [R1]
    end
  end

  // drive value and enable; the register inversion applies to stored data
  wire out_reg_val = cfg.out_invert ? ~out_q : out_q;          // [R9]
  wire ddr_val     = out_clk_q ? d_rise : d_fall;              // [R10]
  wire sdr_val     = cfg.out_reg_en ? out_reg_val : core_out_in[0]; // [R14]
  wire data_val    = serdes_on        ? ser_bit :
                     cfg.dual_edge_io ? ddr_val : sdr_val;
  wire oe_val      = cfg.oe_reg_en ? oe_q : core_oe_in;        // [R15]

  logic next_oe;
  logic next_pad;
  always_comb begin
    next_oe  = 1'b0;
    next_pad = 1'b0;
    if (clk_on) begin
      next_oe  = 1'b1;
      next_pad = tree_q;                                       // [R16]
    end else if (tx_on && cfg.mode == fpioc_pkg::FPIOC_OUT) begin
      next_oe  = 1'b1;                                         // [R7]
      next_pad = data_val;
    end else if (tx_on) begin
      next_oe  = oe_val;                                       // [R11]
      next_pad = oe_val & data_val;                            // [R23]
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_in_out   <= 2'h0;
      alt_out       <= 1'b0;
      pad_oe_out    <= 1'b0;
      pad_out_out   <= 1'b0;
      pull_up_out   <= 1'b1;
      pull_down_out <= 1'b0;
    end else begin
      core_in_out   <= next_core_in;
      // one sampling stage only, never a capture register
      alt_out       <= live & cfg.alt_sel & pad_in;            // [R4] [R5]
      pad_oe_out    <= next_oe;
      pad_out_out   <= next_pad;
      pull_up_out   <= cfg_busy_in |
                       (~cfg.pin_used & ~cfg.pull_down_sel);   // [R17] [R18]
      pull_down_out <= user_mode & ~cfg.pin_used &
                       cfg.pull_down_sel;                      // [R19]
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_in_only;
    (live && cfg.mode == fpioc_pkg::FPIOC_IN) |=> !pad_oe_out;
  endproperty
  a_in_only: assert property (p_in_only) // [R1]
    else $error("input mode drove the pad");

  property p_in_reg;
    (rx_on && cfg.in_reg_en && !cfg.dual_edge_io)
      |=> core_in_out == {1'b0, $past(in_cap)};
  endproperty
  a_in_reg: assert property (p_in_reg) // [R3]
    else $error("registered input not taken from capture register");

  property p_alt;
    (live && cfg.alt_sel) |=> alt_out == $past(pad_in);
  endproperty
  a_alt: assert property (p_alt) // [R4]
    else $error("alternate input not a direct pad copy");

  property p_dual_edge_io_rise;
    in_rise |=> rise_cap == $past(pad_in);
  endproperty
  a_dual_edge_io_rise: assert property (p_dual_edge_io_rise) // [R6]
    else $error("rising sample not captured");

  property p_dual_edge_io_cap;
    in_fall |=> fall_cap == $past(pad_in);
  endproperty
  a_dual_edge_io_cap: assert property (p_dual_edge_io_cap) // [R6]
    else $error("falling sample not captured");

  property p_out_only;
    (live && cfg.mode == fpioc_pkg::FPIOC_OUT) |=> pad_oe_out;
  endproperty
  a_out_only: assert property (p_out_only) // [R7]
    else $error("output mode left pad released");

  property p_invert;
    (tx_on && cfg.mode == fpioc_pkg::FPIOC_OUT && cfg.out_reg_en &&
     cfg.out_invert && !cfg.dual_edge_io && !serdes_on)
      |=> pad_out_out == ~$past(out_q);
  endproperty
  a_invert: assert property (p_invert) // [R9]
    else $error("inverted output register value wrong");

  property p_clkout;
    clk_on |=> pad_oe_out && pad_out_out == $past(tree_q);
  endproperty
  a_clkout: assert property (p_clkout) // [R16]
    else $error("clock tree not forwarded");

  property p_cfg_pull;
    cfg_busy_in |=> pull_up_out && !pull_down_out && !pad_oe_out;
  endproperty
  a_cfg_pull: assert property (p_cfg_pull) // [R17]
    else $error("pin not weak pull-up during configuration");

  property p_release;
    !pad_oe_out |-> !pad_out_out;
  endproperty
  a_release: assert property (p_release) // [R23]
    else $error("pad data present while released");

endmodule

// ### inc/fpioc_pkg.sv
// constants, register map and types for the pin i/o logic cell
package fpioc_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [7:0]  FPIOC_ADR_CTRL   = 8'h00;
  localparam logic [7:0]  FPIOC_ADR_STAT   = 8'h04;
  localparam logic [7:0]  FPIOC_ADR_SER_TX = 8'h08;
  localparam logic [7:0]  FPIOC_ADR_SER_RX = 8'h0C;

  // values after reset
  localparam logic [15:0] FPIOC_CTRL_RST   = 16'h0000;
  localparam logic [3:0]  FPIOC_SER_RST    = 4'h0;

  // serializer ratio 1:4, last slot index of a word
  localparam logic [1:0]  FPIOC_SER_LAST   = 2'h3;

  // status register bit positions
  localparam int          FPIOC_ST_PAD     = 0;
  localparam int          FPIOC_ST_CORE_LO = 1;
  localparam int          FPIOC_ST_CORE_HI = 2;
  localparam int          FPIOC_ST_OE      = 3;
  localparam int          FPIOC_ST_ALT     = 4;
  localparam int          FPIOC_ST_BUSY    = 5;

  typedef enum logic [1:0] {
    FPIOC_IN     = 2'h0,
    FPIOC_OUT    = 2'h1,
    FPIOC_BIDIR  = 2'h3,
    FPIOC_CLKOUT = 2'h2
  } fpioc_mode_t;

  typedef enum logic [1:0] {
    FPIOC_DUAL_EDGE_IO_NORMAL = 2'h0,
    FPIOC_DUAL_EDGE_IO_RESYNC = 2'h1,
    FPIOC_DUAL_EDGE_IO_PIPE   = 2'h3
  } fpioc_dual_edge_io_t;

  // control register layout, bit 15 down to bit 0
  typedef struct packed {
    logic        pin_used;
    logic        serdes_en;
    logic        pull_down_sel;
    logic        alt_sel;
    fpioc_dual_edge_io_t dual_edge_io_kind;
    logic        dual_edge_io;
    logic        out_invert;
    logic        oe_edge_fall;
    logic        out_edge_fall;
    logic        in_edge_fall;
    logic        oe_reg_en;
    logic        out_reg_en;
    logic        in_reg_en;
    fpioc_mode_t mode;
  } fpioc_cfg_t;

endpackage

// ### tb/fpioc_core_model.sv
// core fabric and pad model facing the pin cell
`timescale 1ns/1ps
module fpioc_core_model (
  input  wire logic       clk_sys_in,
  input  wire logic       pad_drv_in,
  input  wire logic       pad_oe_in,
  input  wire logic       pull_up_in,
  output logic            in_clk_out,
  output logic            out_clk_out,
  output logic            clk_tree_out,
  output logic      [1:0] core_out_out,
  output logic            core_oe_out,
  output logic            pad_lvl_out
);
  logic ext_en;
  logic ext_val;
  // released pad settles to ext_val when ext_en is set, else to the pull-up level, never to a stale value
  assign pad_lvl_out = pad_oe_in ? pad_drv_in :
                       (ext_en ? ext_val : pull_up_in);
  initial begin
    {in_clk_out, out_clk_out, clk_tree_out, core_oe_out} = 4'h0;
    core_out_out = 2'h0;
    ext_en = 1'b0;
    ext_val = 1'b0;
  end
  // two cycles per level so the cell sees every high and low
  task automatic hold2();
    repeat (2) @(posedge clk_sys_in);
  endtask
  task automatic in_edge(input logic v);
    @(posedge clk_sys_in) in_clk_out <= v;
    hold2();
  endtask
  task automatic out_edge(input logic v);
    @(posedge clk_sys_in) out_clk_out <= v;
    hold2();
  endtask
  task automatic tree(input logic v);
    @(posedge clk_sys_in) clk_tree_out <= v;
    hold2();
  endtask
  // both bits set well before the launching edge
  task automatic core(input logic [1:0] d, input logic oe);
    @(posedge clk_sys_in) core_out_out <= d;
    core_oe_out <= oe;
    hold2();
  endtask
  task automatic ext(input logic en, input logic v);
    @(posedge clk_sys_in) ext_en <= en;
    ext_val <= v;
    hold2();
  endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the pin i/o logic cell
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        busy;
  logic        in_clk;
  logic        out_clk;
  logic        ctree;
  logic [1:0]  cout;
  logic        coe;
  logic [1:0]  cin;
  logic        alt;
  logic        pad;
  logic        pdo;
  logic        poe;
  logic        pu;
  logic        pd;
  logic [31:0] q;
  int          n_mismatch;
  int          n_tests;

  fpioc_cell fpioc_cell_inst (
    .clk_sys_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .cfg_busy_in(busy),
    .in_clk_in(in_clk), .out_clk_in(out_clk), .clk_tree_in(ctree),
    .core_out_in(cout), .core_oe_in(coe), .core_in_out(cin),
    .alt_out(alt), .pad_in(pad), .pad_out_out(pdo), .pad_oe_out(poe),
    .pull_up_out(pu), .pull_down_out(pd));

  fpioc_core_model fpioc_core_model_inst (
    .clk_sys_in(clk), .pad_drv_in(pdo), .pad_oe_in(poe), .pull_up_in(pu),
    .in_clk_out(in_clk), .out_clk_out(out_clk), .clk_tree_out(ctree),
    .core_out_out(cout), .core_oe_out(coe), .pad_lvl_out(pad));

  always #25 clk = ~clk;

  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  // classic single cycle; no fixed latency assumed
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (i >= 50) chk(32'h0, 32'h1, "no ack");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic cfg(input logic [31:0] d);
    wb(1'b1, fpioc_pkg::FPIOC_ADR_CTRL, d, 4'h3);
  endtask

  initial begin
    wait_n(4000);
    n_mismatch++;
    summarize();
  end

  initial begin
    {clk, rst_n, cyc, stb, we, busy} = 6'h00;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    n_mismatch = 0;
    n_tests = 0;
    wait_n(4);
    rst_n <= 1'b1;
    wait_n(2);
    chk(32'({pu, pd, poe}), 32'h4, "unused pulls");
    wb(1'b0, 8'h10, 32'h0, 4'hF);
    chk(q, 32'h0, "unmapped read");
    $display("test reset done");
    cfg(32'h2000);
    wait_n(4);
    chk(32'({pu, pd, poe}), 32'h2, "pull down");
    busy <= 1'b1;
    wait_n(4);
    chk(32'(pu), 32'h1, "busy pull up");
    busy <= 1'b0;
    $display("test pulls done");
    cfg(32'h8004);
    fpioc_core_model_inst.ext(1'b1, 1'b1);
    wait_n(4);
    chk(32'(cin[0]), 32'h0, "no edge no capture");
    chk(32'(poe), 32'h0, "input only");
    fpioc_core_model_inst.in_edge(1'b1);
    wait_n(4);
    chk(32'(cin[0]), 32'h1, "rise capture");
    fpioc_core_model_inst.in_edge(1'b0);
    cfg(32'h8024);
    fpioc_core_model_inst.ext(1'b1, 1'b0);
    fpioc_core_model_inst.in_edge(1'b1);
    wait_n(4);
    chk(32'(cin[0]), 32'h1, "rise ignored");
    fpioc_core_model_inst.in_edge(1'b0);
    wait_n(4);
    chk(32'(cin[0]), 32'h0, "fall capture");
    cfg(32'h9004);
    fpioc_core_model_inst.ext(1'b1, 1'b1);
    wait_n(4);
    chk(32'(alt), 32'h1, "alt high");
    fpioc_core_model_inst.ext(1'b1, 1'b0);
    wait_n(4);
    chk(32'(alt), 32'h0, "alt low");
    // deserializer: bits 1,0,1,1 arrive lsb first
    cfg(32'hC000);
    for (int k = 0; k < 4; k++) begin
      fpioc_core_model_inst.ext(1'b1, k != 1);
      fpioc_core_model_inst.in_edge(1'b1);
      fpioc_core_model_inst.in_edge(1'b0);
    end
    wb(1'b0, fpioc_pkg::FPIOC_ADR_SER_RX, 32'h0, 4'hF);
    chk(q, 32'h0000000D, "serdes rx word");
    wb(1'b1, fpioc_pkg::FPIOC_ADR_SER_TX, 32'h00000005, 4'h1);
    wb(1'b0, fpioc_pkg::FPIOC_ADR_SER_TX, 32'h0, 4'hF);
    chk(q, 32'h00000005, "serdes tx word");
    $display("test input done");
    cfg(32'h8204);
    for (int k = 0; k < 2; k++) begin
      fpioc_core_model_inst.ext(1'b1, k[0] ? 1'b0 : 1'b1);
      fpioc_core_model_inst.in_edge(1'b1);
      fpioc_core_model_inst.ext(1'b1, k[0] ? 1'b1 : 1'b0);
      fpioc_core_model_inst.in_edge(1'b0);
      wait_n(4);
      chk(32'(cin), k[0] ? 32'h2 : 32'h1, "dual in");
    end
    // resync: pair of the previous cycle shown at the rising edge
    cfg(32'h8604);
    fpioc_core_model_inst.in_edge(1'b1);
    wait_n(4);
    chk(32'(cin), 32'h2, "resync pair");
    fpioc_core_model_inst.in_edge(1'b0);
    cfg(32'h8E04);
    fpioc_core_model_inst.in_edge(1'b1);
    wait_n(4);
    chk(32'(cin), 32'h2, "pipeline pair");
    fpioc_core_model_inst.in_edge(1'b0);
    $display("test dual input done");
    cfg(32'h8109);
    fpioc_core_model_inst.core(2'h0, 1'b0);
    fpioc_core_model_inst.out_edge(1'b1);
    fpioc_core_model_inst.out_edge(1'b0);
    wait_n(4);
    chk(32'({poe, pdo}), 32'h3, "inverted zero");
    fpioc_core_model_inst.core(2'h1, 1'b0);
    wait_n(4);
    chk(32'(pdo), 32'h1, "held until edge");
    fpioc_core_model_inst.out_edge(1'b1);
    wait_n(4);
    chk(32'(pdo), 32'h0, "inverted one");
    fpioc_core_model_inst.out_edge(1'b0);
    cfg(32'h8209);
    fpioc_core_model_inst.core(2'h2, 1'b0);
    fpioc_core_model_inst.out_edge(1'b1);
    wait_n(2);
    chk(32'(pdo), 32'h0, "dual out rise");
    fpioc_core_model_inst.out_edge(1'b0);
    wait_n(3);
    chk(32'(pdo), 32'h1, "dual out fall");
    $display("test output done");
    cfg(32'h8003);
    fpioc_core_model_inst.ext(1'b0, 1'b0);
    fpioc_core_model_inst.core(2'h1, 1'b0);
    wait_n(4);
    chk(32'({poe, pdo}), 32'h0, "released");
    fpioc_core_model_inst.core(2'h1, 1'b1);
    wait_n(4);
    chk(32'({poe, pdo, cin[0]}), 32'h7, "bidir");
    wb(1'b0, fpioc_pkg::FPIOC_ADR_STAT, 32'h0, 4'hF);
    chk(q, 32'h0000000B, "status word");
    wb(1'b0, fpioc_pkg::FPIOC_ADR_CTRL, 32'h0, 4'hF);
    chk(q, 32'h00008003, "control readback");
    cfg(32'h8002);
    fpioc_core_model_inst.tree(1'b1);
    wait_n(3);
    chk(32'(pdo), 32'h1, "clock out high");
    fpioc_core_model_inst.tree(1'b0);
    wait_n(3);
    chk(32'(pdo), 32'h0, "clock out low");
    // only lane 0 enabled: the high byte must keep its value
    wb(1'b1, fpioc_pkg::FPIOC_ADR_CTRL, 32'h0000FF00, 4'h1);
    wb(1'b0, fpioc_pkg::FPIOC_ADR_CTRL, 32'h0, 4'hF);
    chk(q, 32'h00008000, "byte lane write");
    $display("test bidir and clock done");
    summarize();
  end
endmodule
